// ===== include/ufb_cfg.svh
/*
  Offsets, field positions, reset values and timing counts of the USB
  function bridge. Assumes a 16-bit microcontroller register port.
*/
`ifndef UFB_CFG_SVH
`define UFB_CFG_SVH
// Register offsets on the microcontroller port.
`define UFB_OFS_SETUP_CNT 16'h0F00
`define UFB_OFS_CONTROL   16'h0F02
`define UFB_OFS_IRQ       16'h0F04
`define UFB_OFS_ADDR_EP   16'h0F06
`define UFB_OFS_FRAME     16'h0F08
`define UFB_OFS_REQ_KIND  16'h0F0A
`define UFB_OFS_IO_ADDR   16'h2000
`define UFB_OFS_IO_DATA   16'h2002
`define UFB_OFS_EPD_BASE  16'h1000
`define UFB_OFS_EPD_LAST  16'h101C
// Field positions.
`define UFB_IO_START      15
`define UFB_IO_WRITE      14
`define UFB_CTL_READY     0
`define UFB_CTL_REENUM    1
`define UFB_CTL_BOOTRAM   2
`define UFB_IRQ_ACTIVE    0
`define UFB_IRQ_SETUP     1
`define UFB_IRQ_IN        2
`define UFB_IRQ_OUT       3
`define UFB_IRQ_ERR       4
`define UFB_AE_EP_LSB     7
`define UFB_EPD_TYPE_LSB  10
`define UFB_EPD_DIR       12
// Reset values.
`define UFB_RST_CONTROL   3'h0
`define UFB_RST_IRQ       5'h00
`define UFB_RST_WORD      16'h0000
// Timing.
`define UFB_CLK_MHZ       100
`define UFB_REENUM_US     10000
// Endpoint map.
`define UFB_EP0_MAXPKT    10'h008
`define UFB_BULK_MAXPKT   10'h040
`define UFB_FIRST_PROG_EP 4'h4
`define UFB_LAST_PROG_EP  4'hB
`define UFB_LAST_BULK_EP  4'h3
// Setup request codes.
`define UFB_RQT_VEND_OUT  8'h40
`define UFB_RQT_VEND_IN   8'hC0
`define UFB_RQ_FW_DL      8'hA1
`define UFB_RQ_REG_IO     8'hA0
// Descriptor values.
`define UFB_LEN_DEV       8'h12
`define UFB_LEN_CFG       8'h09
`define UFB_LEN_STR0      8'h04
`define UFB_LEN_STR1      8'h14
`define UFB_LEN_STR2      8'h22
`define UFB_DT_DEV        8'h01
`define UFB_DT_CFG        8'h02
`define UFB_DT_STR        8'h03
`define UFB_BCD_USB       16'h0110
`define UFB_VENDOR_CLASS  8'hFF
`define UFB_CFG_TOTAL     8'h12
`define UFB_LANG_ID       16'h0409
`define UFB_STR_FILL      8'h20
`endif

// ===== include/ufb_pkg.sv
/*
  Types of the USB function bridge. Assumes nothing of its surroundings.
*/
package ufb_pkg;
  typedef enum logic [0:0] {
    UFB_IDLE = 1'b0,
    UFB_BUSY = 1'b1
  } ufb_bridge_t;
  typedef enum logic [1:0] {
    UFB_REQ_NONE = 2'b00,
    UFB_REQ_FWDL = 2'b01,
    UFB_REQ_REGW = 2'b10,
    UFB_REQ_REGR = 2'b11
  } ufb_req_t;
  typedef enum logic [1:0] {
    UFB_DSC_DEV = 2'b00,
    UFB_DSC_CFG = 2'b01,
    UFB_DSC_STR = 2'b10
  } ufb_desc_t;
  typedef enum logic [1:0] {
    UFB_EP_OFF  = 2'b00,
    UFB_EP_ISO  = 2'b01,
    UFB_EP_BULK = 2'b10,
    UFB_EP_INTR = 2'b11
  } ufb_ep_type_t;
endpackage

// ===== src/ufb_bridge.sv
/*
  USB function control registers, register-space bridge, vendor request
  decoding, bootstrap descriptors and endpoint map. Assumes that the USB
  engine, the processor register bus and the microcontroller all run on
  ref_clk, so no input needs a synchroniser.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ufb_cfg.svh"

module ufb_bridge #(
  parameter int unsigned REENUM_CYCLES = `UFB_REENUM_US * `UFB_CLK_MHZ
) (
  // Clock and reset.
  input  wire logic                 ref_clk,
  input  wire logic                 reset_n,
  // Microcontroller register port.
  input  wire logic                 mcuSel,
  input  wire logic                 mcuWrite,
  input  wire logic [15:0]          mcuAddr,
  input  wire logic [15:0]          mcuWrData,
  output logic      [15:0]          mcuRdData,
  // Processor register space.
  output logic                      dspReq,
  output logic                      dspWrite,
  output logic      [13:0]          dspAddr,
  output logic      [15:0]          dspWrData,
  input  wire logic                 dspAck,
  input  wire logic [15:0]          dspRdData,
  // USB engine events.
  input  wire logic                 tokSetup,
  input  wire logic                 tokIn,
  input  wire logic                 tokOut,
  input  wire logic [3:0]           tokEndpoint,
  input  wire logic [63:0]          setupPkt,
  input  wire logic                 sofValid,
  input  wire logic [10:0]          sofFrame,
  input  wire logic                 outByteValid,
  input  wire logic [7:0]           outByte,
  // Function control.
  output logic                      mcuIrq,
  output logic                      ep0Stall,
  output logic                      usbAttach,
  output logic                      useDownloadedCfg,
  output logic                      firmwareReady,
  output logic                      bootFromRam,
  // Microcontroller code download.
  output logic                      codeWe,
  output logic      [15:0]          codeAddr,
  output logic      [7:0]           codeData,
  // Descriptors.
  input  wire ufb_pkg::ufb_desc_t   descSel,
  input  wire logic [1:0]           descIndex,
  input  wire logic [5:0]           descOffset,
  input  wire logic [47:0]          eeDevBytes,
  input  wire logic [15:0]          eeCfgBytes,
  output logic      [7:0]           descData,
  output logic      [7:0]           descLength,
  // Endpoint map.
  input  wire logic [3:0]           epQuery,
  output ufb_pkg::ufb_ep_type_t     epType,
  output logic                      epDirIn,
  output logic      [9:0]           epMaxPkt
);
  import ufb_pkg::*;

  // Every check below runs on ref_clk and rests while reset is held.
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);

  localparam int CW = $clog2(REENUM_CYCLES + 1);

  logic [3:0]  setupCnt_r;
  logic [2:0]  control_r;
  logic [4:0]  irq_r;
  logic [6:0]  usbAddr_r;
  logic [3:0]  lastEp_r;
  logic [10:0] frame_r;
  ufb_req_t    reqKind_r;
  logic [15:0] ioAddr_r;
  logic [15:0] ioData_r;
  logic [15:0] epDesc_r [8];
  ufb_bridge_t state_r;
  logic [CW-1:0] reenumCnt_r;
  logic        dlActive_r;
  logic [15:0] dlAddr_r;

  // Write strobe decoding shared by every writable register; the frame and request kind registers have none.
  function automatic logic hit(input logic [15:0] ofs);
    return mcuSel && mcuWrite && (mcuAddr == ofs);
  endfunction

  logic [15:0] wLength;
  logic        tokAny;
  logic        ioLaunch;
  logic        ioDone;
  assign wLength  = setupPkt[63:48];
  assign tokAny   = tokSetup | tokIn | tokOut;
  assign ioLaunch = (state_r == UFB_IDLE) && hit(`UFB_OFS_IO_ADDR)
                    && mcuWrData[`UFB_IO_START];
  assign ioDone   = (state_r == UFB_BUSY) && dspAck;

  // Data-stage byte count, loaded from each setup and saturated.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      setupCnt_r <= 4'h0;
    end else if (tokSetup) begin
      setupCnt_r <= (|wLength[15:4]) ? 4'hF : wLength[3:0];
    end else if (hit(`UFB_OFS_SETUP_CNT)) begin
      setupCnt_r <= mcuWrData[3:0];
    end
  end

  // Control register; the reenumerate bit reads one until reattach.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      control_r <= `UFB_RST_CONTROL;
    end else if (hit(`UFB_OFS_CONTROL)) begin
      control_r[`UFB_CTL_READY]   <= mcuWrData[`UFB_CTL_READY];
      control_r[`UFB_CTL_BOOTRAM] <= mcuWrData[`UFB_CTL_BOOTRAM];
      if (mcuWrData[`UFB_CTL_REENUM]) begin
        control_r[`UFB_CTL_REENUM] <= 1'b1;
      end
    end else if (control_r[`UFB_CTL_REENUM]
                 && reenumCnt_r == CW'(REENUM_CYCLES - 1)) begin
      control_r[`UFB_CTL_REENUM] <= 1'b0;
    end
  end

  // Detach timer and attach control of the pull-up.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      reenumCnt_r      <= '0;
      usbAttach        <= 1'b0;
      useDownloadedCfg <= 1'b0;
      firmwareReady    <= 1'b0;
      bootFromRam      <= 1'b0;
    end else begin
      firmwareReady <= control_r[`UFB_CTL_READY];
      bootFromRam   <= control_r[`UFB_CTL_BOOTRAM];
      if (control_r[`UFB_CTL_REENUM]) begin
        reenumCnt_r <= reenumCnt_r + CW'(1);
        usbAttach   <= 1'b0;
        if (reenumCnt_r == CW'(REENUM_CYCLES - 1)) begin
          useDownloadedCfg <= 1'b1;
        end
      end else begin
        reenumCnt_r <= '0;
        usbAttach   <= control_r[`UFB_CTL_READY];
      end
    end
  end

  // Token flags: set wins over the write-one-to-clear.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_r <= `UFB_RST_IRQ;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (hit(`UFB_OFS_IRQ) && mcuWrData[i]) begin
          irq_r[i] <= 1'b0;
        end
      end
      if (hit(`UFB_OFS_IRQ)) begin
        irq_r[`UFB_IRQ_ERR] <= mcuWrData[`UFB_IRQ_ERR];
      end
      if (tokAny) begin
        irq_r[`UFB_IRQ_ACTIVE] <= 1'b1;
      end
      if (tokSetup) begin
        irq_r[`UFB_IRQ_SETUP] <= 1'b1;
      end
      if (tokIn) begin
        irq_r[`UFB_IRQ_IN] <= 1'b1;
      end
      if (tokOut) begin
        irq_r[`UFB_IRQ_OUT] <= 1'b1;
      end
    end
  end

  // Interrupt line and endpoint zero stall follow the flags.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      mcuIrq   <= 1'b0;
      ep0Stall <= 1'b0;
    end else begin
      mcuIrq   <= irq_r[`UFB_IRQ_ACTIVE];
      ep0Stall <= irq_r[`UFB_IRQ_ERR];
    end
  end

  // Bus address, last endpoint and frame number.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      usbAddr_r <= 7'h00;
      lastEp_r  <= 4'h0;
      frame_r   <= 11'h000;
    end else begin
      if (hit(`UFB_OFS_ADDR_EP)) begin
        usbAddr_r <= mcuWrData[6:0];
        lastEp_r  <= mcuWrData[`UFB_AE_EP_LSB +: 4];
      end
      if (tokAny) begin
        lastEp_r <= tokEndpoint;
      end
      if (sofValid) begin
        frame_r <= sofFrame;
      end
    end
  end

  // Vendor request decoding and code download address.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      reqKind_r  <= UFB_REQ_NONE;
      dlActive_r <= 1'b0;
      dlAddr_r   <= `UFB_RST_WORD;
      codeWe     <= 1'b0;
      codeAddr   <= `UFB_RST_WORD;
      codeData   <= 8'h00;
    end else begin
      codeWe <= 1'b0;
      if (tokSetup) begin
        reqKind_r  <= UFB_REQ_NONE;
        dlActive_r <= 1'b0;
        if (setupPkt[7:0] == `UFB_RQT_VEND_OUT
            && setupPkt[15:8] == `UFB_RQ_FW_DL) begin
          reqKind_r  <= UFB_REQ_FWDL;
          dlActive_r <= 1'b1;
          dlAddr_r   <= setupPkt[31:16];
        end else if (setupPkt[15:8] == `UFB_RQ_REG_IO) begin
          if (setupPkt[7:0] == `UFB_RQT_VEND_OUT) begin
            reqKind_r <= UFB_REQ_REGW;
          end else if (setupPkt[7:0] == `UFB_RQT_VEND_IN) begin
            reqKind_r <= UFB_REQ_REGR;
          end
        end
      end else if (dlActive_r && outByteValid) begin
        codeWe   <= 1'b1;
        codeAddr <= dlAddr_r;
        codeData <= outByte;
        dlAddr_r <= dlAddr_r + 16'h0001;
      end
    end
  end

  // Endpoint description registers for the programmable endpoints.
  for (genvar g = 0; g < 8; g++) begin : g_epd
    always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
        epDesc_r[g] <= `UFB_RST_WORD;
      end else if (hit(`UFB_OFS_EPD_BASE + 16'(g * 4))) begin
        epDesc_r[g] <= mcuWrData;
      end
    end
  end

  // Register-space bridge: one cycle per start, start clears at the end.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r   <= UFB_IDLE;
      ioAddr_r  <= `UFB_RST_WORD;
      ioData_r  <= `UFB_RST_WORD;
      dspReq    <= 1'b0;
      dspWrite  <= 1'b0;
      dspAddr   <= 14'h0000;
      dspWrData <= `UFB_RST_WORD;
    end else begin
      unique case (state_r)
        UFB_IDLE: begin
          if (hit(`UFB_OFS_IO_ADDR)) begin
            ioAddr_r <= mcuWrData;
          end
          if (hit(`UFB_OFS_IO_DATA)) begin
            ioData_r <= mcuWrData;
          end
          if (ioLaunch) begin
            state_r   <= UFB_BUSY;
            dspReq    <= 1'b1;
            dspWrite  <= mcuWrData[`UFB_IO_WRITE];
            dspAddr   <= mcuWrData[13:0];
            dspWrData <= ioData_r;
          end
        end
        UFB_BUSY: begin
          if (dspAck) begin
            state_r <= UFB_IDLE;
            dspReq  <= 1'b0;
            ioAddr_r[`UFB_IO_START] <= 1'b0;
            if (!dspWrite) begin
              ioData_r <= dspRdData;
            end
          end
        end
      endcase
    end
  end

  // Register read port, one cycle behind the select.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      mcuRdData <= `UFB_RST_WORD;
    end else if (mcuSel && !mcuWrite) begin
      mcuRdData <= `UFB_RST_WORD;
      case (mcuAddr)
        `UFB_OFS_SETUP_CNT: mcuRdData[3:0]  <= setupCnt_r;
        `UFB_OFS_CONTROL:   mcuRdData[2:0]  <= control_r;
        `UFB_OFS_IRQ:       mcuRdData[4:0]  <= irq_r;
        `UFB_OFS_ADDR_EP:   mcuRdData[10:0] <= {lastEp_r, usbAddr_r};
        `UFB_OFS_FRAME:     mcuRdData[10:0] <= frame_r;
        `UFB_OFS_REQ_KIND:  mcuRdData[1:0]  <= reqKind_r;
        `UFB_OFS_IO_ADDR:   mcuRdData       <= ioAddr_r;
        `UFB_OFS_IO_DATA:   mcuRdData       <= ioData_r;
        default: begin
          if (mcuAddr >= `UFB_OFS_EPD_BASE && mcuAddr <= `UFB_OFS_EPD_LAST
              && mcuAddr[1:0] == 2'b00) begin
            mcuRdData <= epDesc_r[mcuAddr[4:2]];
          end
        end
      endcase
    end
  end

  // Bootstrap descriptor bytes; beyond the length reads zero, except even offsets of strings 1 to 3, which read the fill byte.
  function automatic logic [7:0] descByte(input ufb_desc_t s,
      input logic [1:0] idx, input logic [5:0] o);
    logic [7:0] b;
    b = 8'h00;
    unique case (s)
      UFB_DSC_DEV: begin
        case (o)
          6'd0: b = `UFB_LEN_DEV;
          6'd1: b = `UFB_DT_DEV;
          6'd2: b = 8'(`UFB_BCD_USB & 16'h00FF);
          6'd3: b = 8'(`UFB_BCD_USB >> 8);
          6'd4, 6'd5, 6'd6: b = `UFB_VENDOR_CLASS;
          6'd7: b = 8'(`UFB_EP0_MAXPKT);
          6'd8, 6'd9, 6'd10, 6'd11, 6'd12, 6'd13:
            b = eeDevBytes[{o[2:0], 3'b000} +: 8];
          6'd14: b = 8'h01;
          6'd15: b = 8'h02;
          6'd17: b = 8'h01;
          default: b = 8'h00;
        endcase
      end
      UFB_DSC_CFG: begin
        case (o)
          6'd0: b = `UFB_LEN_CFG;
          6'd1: b = `UFB_DT_CFG;
          6'd2: b = `UFB_CFG_TOTAL;
          6'd4, 6'd5: b = 8'h01;
          6'd7: b = eeCfgBytes[7:0];
          6'd8: b = eeCfgBytes[15:8];
          default: b = 8'h00;
        endcase
      end
      UFB_DSC_STR: begin
        if (o == 6'd0) begin
          b = (idx == 2'd0) ? `UFB_LEN_STR0 :
              (idx == 2'd1) ? `UFB_LEN_STR1 : `UFB_LEN_STR2;
        end else if (o == 6'd1) begin
          b = `UFB_DT_STR;
        end else if (idx == 2'd0) begin
          b = (o == 6'd2) ? 8'(`UFB_LANG_ID & 16'hFF) :
              (o == 6'd3) ? 8'(`UFB_LANG_ID >> 8) : 8'h00;
        end else if (!o[0]) begin
          b = `UFB_STR_FILL;
        end
      end
      default: b = 8'h00;
    endcase
    return b;
  endfunction

  // Descriptor read port, one cycle behind the request.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      descData   <= 8'h00;
      descLength <= 8'h00;
    end else begin
      descData   <= descByte(descSel, descIndex, descOffset);
      descLength <= descByte(descSel, descIndex, 6'd0);
    end
  end

  // Endpoint map; only endpoint zero exists before reattach.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      epType   <= UFB_EP_OFF;
      epDirIn  <= 1'b0;
      epMaxPkt <= 10'h000;
    end else if (epQuery == 4'h0) begin
      epType   <= UFB_EP_OFF;
      epDirIn  <= 1'b0;
      epMaxPkt <= `UFB_EP0_MAXPKT;
    end else if (!useDownloadedCfg || epQuery > `UFB_LAST_PROG_EP) begin
      epType   <= UFB_EP_OFF;
      epDirIn  <= 1'b0;
      epMaxPkt <= 10'h000;
    end else if (epQuery <= `UFB_LAST_BULK_EP) begin
      epType   <= UFB_EP_BULK;
      epDirIn  <= 1'b0;
      epMaxPkt <= `UFB_BULK_MAXPKT;
    end else begin
      epType   <= ufb_ep_type_t'(
        epDesc_r[3'(epQuery - `UFB_FIRST_PROG_EP)][`UFB_EPD_TYPE_LSB +: 2]);
      epDirIn  <= epDesc_r[3'(epQuery - `UFB_FIRST_PROG_EP)][`UFB_EPD_DIR];
      epMaxPkt <= epDesc_r[3'(epQuery - `UFB_FIRST_PROG_EP)][9:0];
    end
  end

  // Checks beside the logic.
  sequence s_launch;
    ioLaunch;
  endsequence
  sequence s_done;
    (state_r == UFB_BUSY) && dspAck;
  endsequence

  chk_io_launch: assert property (
    s_launch |=> dspReq && ioAddr_r[`UFB_IO_START]
      && dspAddr == $past(mcuWrData[13:0]))
    else $error("register cycle not launched");
  chk_io_dir: assert property (
    s_launch |=> dspWrite == $past(mcuWrData[`UFB_IO_WRITE]))
    else $error("register cycle direction wrong");
  chk_io_rdata: assert property (
    s_done ##0 !dspWrite |=> ioData_r == $past(dspRdData))
    else $error("read data not captured");
  chk_start_clear: assert property (
    s_done |=> !ioAddr_r[`UFB_IO_START] && !dspReq)
    else $error("start bit not cleared");
  chk_irq_set: assert property (
    tokSetup |=> irq_r[`UFB_IRQ_SETUP] ##1 mcuIrq)
    else $error("setup interrupt missing");
  chk_irq_hold: assert property (
    irq_r[`UFB_IRQ_IN] && !hit(`UFB_OFS_IRQ) |=> irq_r[`UFB_IRQ_IN])
    else $error("interrupt flag dropped");
  chk_stall: assert property (
    hit(`UFB_OFS_IRQ) && mcuWrData[`UFB_IRQ_ERR] |=> ##1 ep0Stall)
    else $error("stall not raised");
  chk_frame: assert property (
    sofValid |=> frame_r == $past(sofFrame))
    else $error("frame number not captured");
  chk_last_ep: assert property (
    tokAny |=> lastEp_r == $past(tokEndpoint))
    else $error("last endpoint not captured");
  chk_dl_incr: assert property (
    dlActive_r && outByteValid && !tokSetup
      |=> codeWe && dlAddr_r == codeAddr + 16'h0001)
    else $error("download address not advanced");
  chk_reenum: assert property (
    hit(`UFB_OFS_CONTROL) && mcuWrData[`UFB_CTL_REENUM] |=> ##1 !usbAttach)
    else $error("device not detached");
  chk_boot_src: assert property (
    hit(`UFB_OFS_CONTROL)
      |=> ##1 bootFromRam == $past(mcuWrData[`UFB_CTL_BOOTRAM], 2))
    else $error("boot source not followed");
endmodule // ufb_bridge
`default_nettype wire

// ===== test/ufb_dsp_model.sv
/*
  Processor register space model that answers bridge cycles.
  Assumes the bridge holds each request until it is acknowledged.
*/
`timescale 1ns/1ps
`default_nettype none
module ufb_dsp_model #(
  parameter int unsigned LAT = 3
) (
  // Clock and reset.
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  // Register cycle.
  input  wire logic        dspReq,
  input  wire logic        dspWrite,
  input  wire logic [13:0] dspAddr,
  input  wire logic [15:0] dspWrData,
  output logic             dspAck,
  output logic      [15:0] dspRdData
);
  logic [15:0] mem [16];
  logic [3:0]  waitCnt;
  logic        doneR;
  // Acknowledge each cycle once, after LAT idle cycles of waiting.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      waitCnt <= 4'h0;
      doneR   <= 1'b0;
      dspAck  <= 1'b0;
    end else begin
      dspAck  <= 1'b0;
      waitCnt <= dspReq ? waitCnt + 4'h1 : 4'h0;
      doneR   <= dspReq & doneR;
      if (dspReq && !doneR && waitCnt == LAT[3:0]) begin
        dspAck <= 1'b1;
        doneR  <= 1'b1;
        if (dspWrite) mem[dspAddr[3:0]] <= dspWrData;
      end
    end
  end
  // Read data is only good with the acknowledge, so it is scrambled otherwise.
  assign dspRdData = dspAck ? mem[dspAddr[3:0]] : ~mem[dspAddr[3:0]];
endmodule // ufb_dsp_model
`default_nettype wire

// ===== test/ufb_bridge_test.sv
/*
  Self-checking bench of the USB function bridge.
  Assumes the processor register model of this folder.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ufb_cfg.svh"
module ufb_bridge_test;
  import ufb_pkg::*;
  localparam int unsigned REENUM = 20;
  logic ref_clk, reset_n, mcuSel, mcuWrite, dspReq, dspWrite, dspAck, tokSetup;
  logic tokIn, tokOut, sofValid, outByteValid, mcuIrq, ep0Stall, usbAttach;
  logic useDownloadedCfg, firmwareReady, bootFromRam, codeWe, epDirIn;
  logic [15:0] mcuAddr, mcuWrData, mcuRdData, dspWrData, dspRdData, codeAddr;
  logic [15:0] eeCfgBytes, seenData, lastCode, v;
  logic [13:0] dspAddr, seenAddr;
  logic [3:0]  tokEndpoint, epQuery;
  logic [63:0] setupPkt;
  logic [10:0] sofFrame;
  logic [7:0]  outByte, codeData, descData, descLength;
  logic [1:0]  descIndex;
  logic [5:0]  descOffset;
  logic [47:0] eeDevBytes;
  logic [9:0]  epMaxPkt;
  logic        seenWr;
  ufb_desc_t    descSel;
  ufb_ep_type_t epType;
  int nErrors, nChecks, nCode, cycles;
  ufb_bridge #(.REENUM_CYCLES(REENUM)) i_ufb_bridge (.ref_clk, .reset_n,
    .mcuSel, .mcuWrite, .mcuAddr, .mcuWrData, .mcuRdData, .dspReq, .dspWrite,
    .dspAddr, .dspWrData, .dspAck, .dspRdData, .tokSetup, .tokIn, .tokOut,
    .tokEndpoint, .setupPkt, .sofValid, .sofFrame, .outByteValid, .outByte,
    .mcuIrq, .ep0Stall, .usbAttach, .useDownloadedCfg, .firmwareReady,
    .bootFromRam, .codeWe, .codeAddr, .codeData, .descSel, .descIndex,
    .descOffset, .eeDevBytes, .eeCfgBytes, .descData, .descLength, .epQuery,
    .epType, .epDirIn, .epMaxPkt);
  ufb_dsp_model i_ufb_dsp_model (.ref_clk, .reset_n, .dspReq, .dspWrite,
    .dspAddr, .dspWrData, .dspAck, .dspRdData);
  // Clock, cycle limit and capture of bridge and download traffic.
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      nErrors++;
      testDone();
    end
    if (dspReq === 1'b1) begin
      {seenAddr, seenWr, seenData} <= {dspAddr, dspWrite, dspWrData};
    end
    if (codeWe === 1'b1) begin
      nCode++;
      lastCode <= {codeData, codeAddr[7:0]};
    end
  end
  task automatic chk(input string nm, input logic [15:0] s,
                     input logic [15:0] e);
    nChecks++;
    if (s !== e) begin
      nErrors++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic acc(input logic w, input logic [15:0] a,
                     input logic [15:0] d);
    @(posedge ref_clk);
    {mcuSel, mcuWrite, mcuAddr, mcuWrData} <= {1'b1, w, a, d};
    @(posedge ref_clk);
    mcuSel <= 1'b0;
    #1 v = mcuRdData;
  endtask
  task automatic tok(input logic [2:0] k, input logic [3:0] ep);
    @(posedge ref_clk);
    {tokSetup, tokIn, tokOut, tokEndpoint} <= {k, ep};
    @(posedge ref_clk);
    {tokSetup, tokIn, tokOut} <= 3'h0;
    repeat (2) @(posedge ref_clk);
  endtask
  // Launches one bridge cycle and polls the start bit until it drops.
  task automatic launch(input logic [15:0] a);
    acc(1'b1, `UFB_OFS_IO_ADDR, a);
    for (int n = 0; n < 30; n++) begin
      if (n == 0 || v[15] !== 1'b0) acc(1'b0, `UFB_OFS_IO_ADDR, 16'h0);
    end
    chk("startBit", {15'h0, v[15]}, 16'h0);
  endtask
  task automatic t_frame();
    acc(1'b0, `UFB_OFS_IRQ, 16'h0);
    chk("irqReset", v, 16'h0);
    @(posedge ref_clk);
    {sofValid, sofFrame} <= {1'b1, 11'h5A5};
    @(posedge ref_clk);
    sofValid <= 1'b0;
    acc(1'b1, `UFB_OFS_FRAME, 16'hFFFF);
    acc(1'b0, `UFB_OFS_FRAME, 16'h0);
    chk("frame", v, 16'h05A5);
  endtask
  task automatic t_bridge();
    acc(1'b1, `UFB_OFS_IO_DATA, 16'hBEEF);
    launch(16'hEA03);
    chk("wrCycle", {seenWr, seenAddr, 1'b0}, 16'hD406);
    chk("wrData", seenData, 16'hBEEF);
    acc(1'b1, `UFB_OFS_IO_DATA, 16'h0000);
    launch(16'hAA03);
    chk("rdDir", {15'h0, seenWr}, 16'h0);
    acc(1'b0, `UFB_OFS_IO_DATA, 16'h0);
    chk("rdData", v, 16'hBEEF);
  endtask
  task automatic t_token();
    for (int i = 0; i < 3; i++) begin
      tok(3'b100 >> i, 4'h5);
      chk("mcuIrq", {15'h0, mcuIrq}, 16'h1);
      acc(1'b0, `UFB_OFS_IRQ, 16'h0);
      chk("flags", v, 16'h1 | (16'h2 << i));
      acc(1'b1, `UFB_OFS_IRQ, 16'h000F);
      acc(1'b0, `UFB_OFS_IRQ, 16'h0);
      chk("cleared", v, 16'h0);
    end
    acc(1'b1, `UFB_OFS_ADDR_EP, 16'h02AA);
    acc(1'b0, `UFB_OFS_ADDR_EP, 16'h0);
    chk("addrEp", v, 16'h02AA);
    acc(1'b1, `UFB_OFS_IRQ, 16'h0010);
    repeat (2) @(posedge ref_clk);
    chk("stall", {15'h0, ep0Stall}, 16'h1);
  endtask
  task automatic t_download();
    setupPkt <= 64'h0003_0000_1234_A140;
    tok(3'b100, 4'h0);
    acc(1'b0, `UFB_OFS_SETUP_CNT, 16'h0);
    chk("setupCnt", v, 16'h0003);
    for (int i = 0; i < 3; i++) begin
      @(posedge ref_clk);
      {outByteValid, outByte} <= {1'b1, 8'hC0 + 8'(i)};
    end
    @(posedge ref_clk);
    outByteValid <= 1'b0;
    repeat (3) @(posedge ref_clk);
    chk("codeLast", lastCode, 16'hC236);
    chk("codeCount", 16'(nCode), 16'h3);
    chk("codeAddr", codeAddr, 16'h1236);
    acc(1'b0, `UFB_OFS_REQ_KIND, 16'h0);
    chk("reqKind", v, 16'h0001);
    // Register-access requests, first the write, then the read kind.
    for (int i = 0; i < 2; i++) begin
      setupPkt <= {48'h0002_0000_0005, (i == 0) ? 16'hA040 : 16'hA0C0};
      tok(3'b100, 4'h0);
      acc(1'b0, `UFB_OFS_REQ_KIND, 16'h0);
      chk("reqKind", v, 16'h0002 + 16'(i));
    end
  endtask
  task automatic dchk(input ufb_desc_t s, input logic [1:0] x,
                      input logic [5:0] o, input logic [15:0] e);
    @(posedge ref_clk);
    {descSel, descIndex, descOffset} <= {s, x, o};
    repeat (2) @(posedge ref_clk);
    chk("descriptor", {descLength, descData}, e);
  endtask
  task automatic t_ctrl();
    acc(1'b1, `UFB_OFS_CONTROL, 16'h0005);
    repeat (2) @(posedge ref_clk);
    chk("ctlOut", {13'h0, firmwareReady, bootFromRam, usbAttach},
        16'h0007);
    acc(1'b1, `UFB_OFS_CONTROL, 16'h0007);
    repeat (4) @(posedge ref_clk);
    chk("detached", {15'h0, usbAttach}, 16'h0);
    repeat (REENUM + 4) @(posedge ref_clk);
    chk("reattach", {14'h0, usbAttach, useDownloadedCfg}, 16'h0003);
    acc(1'b1, `UFB_OFS_EPD_BASE, 16'h1C20);
    epQuery <= 4'h1;
    repeat (2) @(posedge ref_clk);
    chk("ep1", {3'h0, epType, epDirIn, epMaxPkt}, 16'h1040);
    epQuery <= 4'h4;
    repeat (2) @(posedge ref_clk);
    chk("ep4", {3'h0, epType, epDirIn, epMaxPkt}, 16'h1C20);
  endtask
  task automatic testDone();
    $display("errors %0d checks %0d", nErrors, nChecks);
    if (nErrors == 0 && nChecks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Reset, then the scenarios in turn.
  initial begin
    {reset_n, mcuSel, mcuWrite, mcuAddr, mcuWrData, tokSetup, tokIn} = '0;
    {tokOut, tokEndpoint, setupPkt, sofValid, sofFrame, outByteValid} = '0;
    {outByte, descSel, descIndex, descOffset, epQuery} = '0;
    eeDevBytes = 48'hA5A4A3A2A1A0;
    eeCfgBytes = 16'hB1B0;
    repeat (16) @(posedge ref_clk);
    reset_n <= 1'b1;
    t_frame();
    t_bridge();
    t_token();
    t_download();
    dchk(UFB_DSC_DEV, 2'h0, 6'd0, 16'h1212);
    dchk(UFB_DSC_DEV, 2'h0, 6'd2, 16'h1210);
    dchk(UFB_DSC_DEV, 2'h0, 6'd6, 16'h12FF);
    dchk(UFB_DSC_DEV, 2'h0, 6'd7, 16'h1208);
    dchk(UFB_DSC_DEV, 2'h0, 6'd13, 16'h12A5);
    dchk(UFB_DSC_CFG, 2'h0, 6'd2, 16'h0912);
    dchk(UFB_DSC_CFG, 2'h0, 6'd8, 16'h09B1);
    dchk(UFB_DSC_STR, 2'h0, 6'd3, 16'h0404);
    dchk(UFB_DSC_STR, 2'h2, 6'd0, 16'h2222);
    t_ctrl();
    testDone();
  end
endmodule // ufb_bridge_test
`default_nettype wire
